// ===== core/rsalu_top.v
// What this block does
// - Rotate-left-through-carry on memory: carry into bit 0, bit 7 to carry, only carry.
// - Same left rotation through carry, result to accumulator, memory kept, only carry.
// - Plain rotate right on memory, bit 0 wraps to bit 7, no flags.
// - Plain rotate right of memory byte into accumulator; memory and flags kept.
// - Rotate-right-through-carry on memory: carry into bit 7, bit 0 to carry.
// - Same right rotation through carry into accumulator; memory kept, only carry.
// - Accumulator plus inverted memory plus carry into accumulator; all four flags updated.
// - Same borrow subtract stored into memory byte; all four flags updated.
// - Memory minus one back to memory; zero result skips, two cycles; no flags.
// - Memory minus one into accumulator, memory kept; zero skips, two cycles.
// - Set byte writes all ones to memory; flags kept.
// - Set bit forces selected memory bit to one; others and flags kept.
// - Memory plus one back to memory; zero result skips, two cycles; no flags.
// - Memory plus one into accumulator, memory kept; zero skips, two cycles.
// - Selected memory bit set skips next instruction, two cycles; nothing else changes.
// - Accumulator plus inverted memory plus one, to accumulator or memory; four flags.
// - Accumulator plus inverted immediate plus one into accumulator; four flags.
// - Swap nibbles of memory byte, back to memory; flags kept.
// - Swap nibbles of memory byte into accumulator; memory kept.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rsalu_consts.vh"

module rsalu_top #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire CLK_I,
  input wire RSTN_I,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire [2:0] S_AXI_AWPROT_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  // AXI4-Lite write response
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire [2:0] S_AXI_ARPROT_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  // Datapath state
  output wire [7:0] ACC_O,
  output wire [7:0] MEM_O,
  output wire [3:0] FLAGS_O,
  output wire BUSY_O,
  output wire SKIP_O
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DUMMY = 3'b100;

  // Maps a byte address to a register select code
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    reg [7:0] a;
    begin
      a = {addr[7:2], 2'b00};
      case (a)
        `RSALU_OFF_CMD: reg_sel = `RSALU_SEL_CMD;
        `RSALU_OFF_ACC: reg_sel = `RSALU_SEL_ACC;
        `RSALU_OFF_MEM: reg_sel = `RSALU_SEL_MEM;
        `RSALU_OFF_IMM: reg_sel = `RSALU_SEL_IMM;
        `RSALU_OFF_FLAGS: reg_sel = `RSALU_SEL_FLAGS;
        `RSALU_OFF_STATUS: reg_sel = `RSALU_SEL_STATUS;
        `RSALU_OFF_COUNT: reg_sel = `RSALU_SEL_COUNT;
        default: reg_sel = `RSALU_SEL_NONE;
      endcase
    end
  endfunction

  // Architectural state
  reg [7:0] acc;
  reg [7:0] mem;
  reg [7:0] imm;
  reg [3:0] flags;
  reg [4:0] opcode;
  reg [2:0] bit_sel;
  reg [2:0] state;
  reg skip_last;
  reg [1:0] cycles_last;
  reg bad_op;
  reg [15:0] exec_count;
  reg [15:0] skip_count;

  // Write channel holding registers
  reg aw_full;
  reg [ADDR_W-1:0] aw_addr;
  reg w_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ALU results
  wire [7:0] alu_result;
  wire alu_wr_acc;
  wire alu_wr_mem;
  wire [3:0] alu_flags;
  wire alu_skip;
  wire alu_known;

  wire st_idle;
  wire do_write;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire rd_take;
  reg [31:0] rd_word;

  rsalu_alu u_alu (
    .op_i(opcode),
    .bit_i(bit_sel),
    .acc_i(acc),
    .mem_i(mem),
    .imm_i(imm),
    .flags_i(flags),
    .result_o(alu_result),
    .wr_acc_o(alu_wr_acc),
    .wr_mem_o(alu_wr_mem),
    .flags_o(alu_flags),
    .skip_o(alu_skip),
    .known_o(alu_known)
  );

  assign st_idle = (state == ST_IDLE);
  // Register writes wait while an instruction runs, so operands stay stable
  assign do_write = aw_full && w_full && st_idle && !S_AXI_BVALID_O;
  assign wr_sel = reg_sel(aw_addr);
  assign rd_sel = reg_sel(S_AXI_ARADDR_I);

  assign S_AXI_AWREADY_O = !aw_full && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_full && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign rd_take = S_AXI_ARVALID_I && !S_AXI_RVALID_O;

  assign ACC_O = acc;
  assign MEM_O = mem;
  assign FLAGS_O = flags;
  assign BUSY_O = !st_idle;
  assign SKIP_O = skip_last;

  // Address and data are caught independently, in either order
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      aw_full <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `RSALU_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      if (wr_sel == `RSALU_SEL_NONE) begin
        S_AXI_BRESP_O <= `RSALU_RESP_SLVERR;
      end else begin
        S_AXI_BRESP_O <= `RSALU_RESP_OKAY;
      end
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // Read mux; bits above each field read as zero
  always @* begin
    rd_word = 32'h00000000;
    case (rd_sel)
      `RSALU_SEL_CMD: begin
        rd_word[`RSALU_CMD_OP_MSB:`RSALU_CMD_OP_LSB] = opcode;
        rd_word[`RSALU_CMD_BIT_MSB:`RSALU_CMD_BIT_LSB] = bit_sel;
      end
      `RSALU_SEL_ACC: begin
        rd_word[7:0] = acc;
      end
      `RSALU_SEL_MEM: begin
        rd_word[7:0] = mem;
      end
      `RSALU_SEL_IMM: begin
        rd_word[7:0] = imm;
      end
      `RSALU_SEL_FLAGS: begin
        rd_word[3:0] = flags;
      end
      `RSALU_SEL_STATUS: begin
        rd_word[`RSALU_ST_BUSY] = !st_idle;
        rd_word[`RSALU_ST_SKIP] = skip_last;
        rd_word[`RSALU_ST_CYC_MSB:`RSALU_ST_CYC_LSB] = cycles_last;
        rd_word[`RSALU_ST_BADOP] = bad_op;
      end
      `RSALU_SEL_COUNT: begin
        rd_word = {skip_count, exec_count};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Read response
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `RSALU_RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_word;
      if (rd_sel == `RSALU_SEL_NONE) begin
        S_AXI_RRESP_O <= `RSALU_RESP_SLVERR;
      end else begin
        S_AXI_RRESP_O <= `RSALU_RESP_OKAY;
      end
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // Sequencer: a command write starts one execute cycle, a skip adds a dummy cycle
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state <= ST_IDLE;
      opcode <= `RSALU_RST_OP;
      bit_sel <= `RSALU_RST_BIT;
      skip_last <= 1'b0;
      cycles_last <= `RSALU_CYC_PLAIN;
      bad_op <= 1'b0;
      exec_count <= `RSALU_RST_COUNT;
      skip_count <= `RSALU_RST_COUNT;
    end else begin
      case (state)
        ST_IDLE: begin
          if (do_write && wr_sel == `RSALU_SEL_CMD && w_strb[0]) begin
            opcode <= w_data[`RSALU_CMD_OP_MSB:`RSALU_CMD_OP_LSB];
            if (w_strb[1]) begin
              bit_sel <= w_data[`RSALU_CMD_BIT_MSB:`RSALU_CMD_BIT_LSB];
            end
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          skip_last <= alu_skip;
          bad_op <= !alu_known;
          exec_count <= exec_count + 16'h0001;
          if (alu_skip) begin
            // Prefetched instruction discarded: dummy cycle follows
            cycles_last <= `RSALU_CYC_SKIP;
            skip_count <= skip_count + 16'h0001;
            state <= ST_DUMMY;
          end else begin
            cycles_last <= `RSALU_CYC_PLAIN;
            state <= ST_IDLE;
          end
        end
        ST_DUMMY: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Accumulator: software write or ALU result
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      acc <= `RSALU_RST_BYTE;
    end else if (state == ST_EXEC && alu_wr_acc) begin
      acc <= alu_result;
    end else if (do_write && wr_sel == `RSALU_SEL_ACC && w_strb[0]) begin
      acc <= w_data[7:0];
    end
  end

  // Addressed memory byte: written back only by memory-destination forms
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      mem <= `RSALU_RST_BYTE;
    end else if (state == ST_EXEC && alu_wr_mem) begin
      mem <= alu_result;
    end else if (do_write && wr_sel == `RSALU_SEL_MEM && w_strb[0]) begin
      mem <= w_data[7:0];
    end
  end

  // Immediate operand
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      imm <= `RSALU_RST_BYTE;
    end else if (do_write && wr_sel == `RSALU_SEL_IMM && w_strb[0]) begin
      imm <= w_data[7:0];
    end
  end

  // Status flags; the ALU passes unaffected flags through unchanged
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      flags <= `RSALU_RST_FLAGS;
    end else if (state == ST_EXEC) begin
      flags <= alu_flags;
    end else if (do_write && wr_sel == `RSALU_SEL_FLAGS && w_strb[0]) begin
      flags <= w_data[3:0];
    end
  end

endmodule
`default_nettype wire

// ===== core/rsalu_consts.vh
`ifndef RSALU_CONSTS_VH
`define RSALU_CONSTS_VH

// Register byte offsets
`define RSALU_OFF_CMD 8'h00
`define RSALU_OFF_ACC 8'h04
`define RSALU_OFF_MEM 8'h08
`define RSALU_OFF_IMM 8'h0c
`define RSALU_OFF_FLAGS 8'h10
`define RSALU_OFF_STATUS 8'h14
`define RSALU_OFF_COUNT 8'h18

// Register select codes
`define RSALU_SEL_CMD 3'h0
`define RSALU_SEL_ACC 3'h1
`define RSALU_SEL_MEM 3'h2
`define RSALU_SEL_IMM 3'h3
`define RSALU_SEL_FLAGS 3'h4
`define RSALU_SEL_STATUS 3'h5
`define RSALU_SEL_COUNT 3'h6
`define RSALU_SEL_NONE 3'h7

// Command register fields
`define RSALU_CMD_OP_LSB 0
`define RSALU_CMD_OP_MSB 4
`define RSALU_CMD_BIT_LSB 8
`define RSALU_CMD_BIT_MSB 10

// Flag positions
`define RSALU_FLAG_C 0
`define RSALU_FLAG_HC 1
`define RSALU_FLAG_Z 2
`define RSALU_FLAG_SOV 3

// Status positions
`define RSALU_ST_BUSY 0
`define RSALU_ST_SKIP 1
`define RSALU_ST_CYC_LSB 2
`define RSALU_ST_CYC_MSB 3
`define RSALU_ST_BADOP 4

// Reset values
`define RSALU_RST_BYTE 8'h00
`define RSALU_RST_FLAGS 4'h0
`define RSALU_RST_OP 5'h00
`define RSALU_RST_BIT 3'h0
`define RSALU_RST_COUNT 16'h0000

// Execution cycle counts
`define RSALU_CYC_PLAIN 2'h1
`define RSALU_CYC_SKIP 2'h2

// AXI responses
`define RSALU_RESP_OKAY 2'h0
`define RSALU_RESP_SLVERR 2'h2

// Operation codes
`define RSALU_OP_ROT_LEFT_CARRY_MEM 5'h00
`define RSALU_OP_ROT_LEFT_CARRY_TO_ACC 5'h01
`define RSALU_OP_ROT_RIGHT_MEM 5'h02
`define RSALU_OP_ROT_RIGHT_TO_ACC 5'h03
`define RSALU_OP_ROT_RIGHT_CARRY_MEM 5'h04
`define RSALU_OP_ROT_RIGHT_CARRY_TO_ACC 5'h05
`define RSALU_OP_SUB_BORROW_TO_ACC 5'h06
`define RSALU_OP_SUB_BORROW_TO_MEM 5'h07
`define RSALU_OP_DEC_SKIP_ZERO_MEM 5'h08
`define RSALU_OP_DEC_SKIP_ZERO_TO_ACC 5'h09
`define RSALU_OP_SET_BYTE 5'h0a
`define RSALU_OP_SET_BIT 5'h0b
`define RSALU_OP_INC_SKIP_ZERO_MEM 5'h0c
`define RSALU_OP_INC_SKIP_ZERO_TO_ACC 5'h0d
`define RSALU_OP_SKIP_ON_BIT_SET 5'h0e
`define RSALU_OP_SUB_TO_ACC 5'h0f
`define RSALU_OP_SUB_TO_MEM 5'h10
`define RSALU_OP_SUB_IMM 5'h11
`define RSALU_OP_SWAP_MEM 5'h12
`define RSALU_OP_NIBBLE_EXCHANGE_TO_ACC 5'h13

`endif

// ===== core/rsalu_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "rsalu_consts.vh"

module rsalu_alu (
  // Instruction
  input wire [4:0] op_i,
  input wire [2:0] bit_i,
  // Operands
  input wire [7:0] acc_i,
  input wire [7:0] mem_i,
  input wire [7:0] imm_i,
  input wire [3:0] flags_i,
  // Results
  output reg [7:0] result_o,
  output reg wr_acc_o,
  output reg wr_mem_o,
  output reg [3:0] flags_o,
  output reg skip_o,
  output reg known_o
);

  // Returns {signed overflow, zero, half carry, carry, result}: a + ~b + cin
  function [11:0] sub_op;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [8:0] s;
    reg [4:0] h;
    reg sgn_ovf;
    begin
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      sgn_ovf = (a[7] == ~b[7]) && (s[7] != a[7]);
      sub_op = {sgn_ovf, (s[7:0] == 8'h00), h[4], s[8], s[7:0]};
    end
  endfunction

  reg [11:0] sub_res;
  reg [7:0] mem_dec;
  reg [7:0] mem_inc;

  always @* begin
    sub_res = 12'h000;
    mem_dec = mem_i - 8'h01;
    mem_inc = mem_i + 8'h01;
    result_o = mem_i;
    wr_acc_o = 1'b0;
    wr_mem_o = 1'b0;
    flags_o = flags_i;
    skip_o = 1'b0;
    known_o = 1'b1;
    case (op_i)
      `RSALU_OP_ROT_LEFT_CARRY_MEM: begin
        result_o = {mem_i[6:0], flags_i[`RSALU_FLAG_C]};
        flags_o[`RSALU_FLAG_C] = mem_i[7];
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_ROT_LEFT_CARRY_TO_ACC: begin
        result_o = {mem_i[6:0], flags_i[`RSALU_FLAG_C]};
        flags_o[`RSALU_FLAG_C] = mem_i[7];
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_ROT_RIGHT_MEM: begin
        result_o = {mem_i[0], mem_i[7:1]};
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_ROT_RIGHT_TO_ACC: begin
        result_o = {mem_i[0], mem_i[7:1]};
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_ROT_RIGHT_CARRY_MEM: begin
        result_o = {flags_i[`RSALU_FLAG_C], mem_i[7:1]};
        flags_o[`RSALU_FLAG_C] = mem_i[0];
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_ROT_RIGHT_CARRY_TO_ACC: begin
        result_o = {flags_i[`RSALU_FLAG_C], mem_i[7:1]};
        flags_o[`RSALU_FLAG_C] = mem_i[0];
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SUB_BORROW_TO_ACC: begin
        sub_res = sub_op(acc_i, mem_i, flags_i[`RSALU_FLAG_C]);
        result_o = sub_res[7:0];
        flags_o = sub_res[11:8];
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SUB_BORROW_TO_MEM: begin
        sub_res = sub_op(acc_i, mem_i, flags_i[`RSALU_FLAG_C]);
        result_o = sub_res[7:0];
        flags_o = sub_res[11:8];
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_DEC_SKIP_ZERO_MEM: begin
        result_o = mem_dec;
        skip_o = (mem_dec == 8'h00);
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_DEC_SKIP_ZERO_TO_ACC: begin
        result_o = mem_dec;
        skip_o = (mem_dec == 8'h00);
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SET_BYTE: begin
        result_o = 8'hff;
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_SET_BIT: begin
        result_o = mem_i | (8'h01 << bit_i);
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_INC_SKIP_ZERO_MEM: begin
        result_o = mem_inc;
        skip_o = (mem_inc == 8'h00);
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_INC_SKIP_ZERO_TO_ACC: begin
        result_o = mem_inc;
        skip_o = (mem_inc == 8'h00);
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SKIP_ON_BIT_SET: begin
        skip_o = mem_i[bit_i];
      end
      `RSALU_OP_SUB_TO_ACC: begin
        sub_res = sub_op(acc_i, mem_i, 1'b1);
        result_o = sub_res[7:0];
        flags_o = sub_res[11:8];
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SUB_TO_MEM: begin
        sub_res = sub_op(acc_i, mem_i, 1'b1);
        result_o = sub_res[7:0];
        flags_o = sub_res[11:8];
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_SUB_IMM: begin
        sub_res = sub_op(acc_i, imm_i, 1'b1);
        result_o = sub_res[7:0];
        flags_o = sub_res[11:8];
        wr_acc_o = 1'b1;
      end
      `RSALU_OP_SWAP_MEM: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        wr_mem_o = 1'b1;
      end
      `RSALU_OP_NIBBLE_EXCHANGE_TO_ACC: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        wr_acc_o = 1'b1;
      end
      default: begin
        known_o = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== tb/rsalu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rsalu_monitor #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Write channels
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  // Datapath state
  input wire logic [7:0] ACC_O,
  input wire logic [7:0] MEM_O,
  input wire logic [3:0] FLAGS_O,
  input wire logic BUSY_O,
  input wire logic SKIP_O
);
  logic [4:0] op_q;
  logic [2:0] bit_q;
  // Opcode and bit select last accepted at the command word
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      op_q <= 5'h00;
      bit_q <= 3'h0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O &&
                 S_AXI_AWADDR_I[ADDR_W-1:2] == '0 && S_AXI_WSTRB_I[0]) begin
      op_q <= S_AXI_WDATA_I[4:0];
      if (S_AXI_WSTRB_I[1]) begin
        bit_q <= S_AXI_WDATA_I[10:8];
      end
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Skipped instruction: dummy cycle, then idle
  sequence s_dummy;
    BUSY_O && SKIP_O ##1 !BUSY_O;
  endsequence
  sequence s_plain;
    !BUSY_O && !SKIP_O;
  endsequence
  a_busy_bounded: assert property ($rose(BUSY_O) |-> ##[1:2] !BUSY_O)
    else $error("execution lasted more than two cycles");
  a_dummy_holds: assert property (BUSY_O && $past(BUSY_O) |=> $stable(ACC_O) && $stable(MEM_O) && $stable(FLAGS_O))
    else $error("state changed during dummy cycle");
  a_rot_left_mem: assert property ($rose(BUSY_O) && op_q == 5'h00 |=>
    MEM_O == {$past(MEM_O[6:0]), $past(FLAGS_O[0])} && FLAGS_O == {$past(FLAGS_O[3:1]), $past(MEM_O[7])})
    else $error("left rotate through carry wrong");
  a_rot_right_mem: assert property ($rose(BUSY_O) && op_q == 5'h02 |=>
    MEM_O == {$past(MEM_O[0]), $past(MEM_O[7:1])} && $stable(FLAGS_O)) else $error("right rotate wrong");
  a_rot_carry_acc: assert property ($rose(BUSY_O) && op_q == 5'h05 |=>
    ACC_O == {$past(FLAGS_O[0]), $past(MEM_O[7:1])} && $stable(MEM_O) && FLAGS_O[0] == $past(MEM_O[0]))
    else $error("right rotate through carry to acc wrong");
  a_sub_mem: assert property ($rose(BUSY_O) && op_q == 5'h10 |=>
    MEM_O == $past(ACC_O) - $past(MEM_O) && FLAGS_O[0] == ($past(ACC_O) >= $past(MEM_O)) && FLAGS_O[2] == (MEM_O == 8'h00))
    else $error("subtract to memory wrong");
  a_set_byte: assert property ($rose(BUSY_O) && op_q == 5'h0a |=> MEM_O == 8'hff && $stable(FLAGS_O))
    else $error("set byte wrong");
  a_swap_mem: assert property ($rose(BUSY_O) && op_q == 5'h12 |=> MEM_O == {$past(MEM_O[3:0]), $past(MEM_O[7:4])})
    else $error("nibble swap wrong");
  a_inc_acc: assert property ($rose(BUSY_O) && op_q == 5'h0d |=>
    ACC_O == $past(MEM_O) + 8'h01 && $stable(MEM_O) && SKIP_O == (ACC_O == 8'h00)) else $error("increment to acc wrong");
  a_bit_skip: assert property ($rose(BUSY_O) && op_q == 5'h0e && MEM_O[bit_q] |=> s_dummy)
    else $error("bit set did not skip");
  a_dec_skip: assert property ($rose(BUSY_O) && op_q == 5'h08 && MEM_O == 8'h01 |=> s_dummy)
    else $error("zero decrement did not skip");
  a_dec_plain: assert property ($rose(BUSY_O) && op_q == 5'h08 && MEM_O != 8'h01 |=> s_plain)
    else $error("nonzero decrement skipped");
endmodule
bind rsalu_top rsalu_monitor #(.ADDR_W(ADDR_W)) u_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .ACC_O(ACC_O), .MEM_O(MEM_O), .FLAGS_O(FLAGS_O), .BUSY_O(BUSY_O), .SKIP_O(SKIP_O));
`default_nettype wire

// ===== tb/mcu_rotate_subtract_skip_alu_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module mcu_rotate_subtract_skip_alu_tb;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, busy, skip;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] acc, mem;
  wire [3:0] flags;
  integer mismatches = 0, n_checks = 0, k, s, o, skips, runs;
  logic [30:0] vec [0:2];
  logic [20:0] e;
  logic [7:0] va, vm, vi;
  logic [3:0] vf;
  logic [2:0] vb;
  logic [1:0] r;
  logic [31:0] d;
  rsalu_top #(.ADDR_W(8)) dut (.CLK_I(clk), .RSTN_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .ACC_O(acc), .MEM_O(mem), .FLAGS_O(flags), .BUSY_O(busy), .SKIP_O(skip));
  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] st, output logic [1:0] rs);
    integer n;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= dv;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      rs = 2'h3;
      for (n = 0; n < 50 && rs === 2'h3; n++) begin
        @(posedge clk);
        if (awvalid && awready === 1'b1) awvalid <= 1'b0;
        if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          rs = bresp;
          bready <= 1'b0;
        end
      end
      if (rs === 2'h3) begin
        mismatches++;
        finish_test;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    integer n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rs = 2'h3;
      for (n = 0; n < 50 && rs === 2'h3; n++) begin
        @(posedge clk);
        if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
          rs = rresp;
          dv = rdata;
          rready <= 1'b0;
        end
      end
      if (rs === 2'h3) begin
        mismatches++;
        finish_test;
      end
    end
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] dv);
    logic [1:0] rs;
    begin
      wr(a, dv, 4'hf, rs);
      `CHK("bresp", 2'h0, rs)
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [31:0] dv;
    logic [1:0] rs;
    begin
      rd(a, dv, rs);
      `CHK("rdata", ev, dv)
      `CHK("rresp", er, rs)
    end
  endtask
  // Reference result packed as {skip, flags, acc, mem}
  function automatic logic [20:0] model(input logic [4:0] op, input logic [7:0] a, m, i, input logic [3:0] f,
                                        input logic [2:0] b);
    logic [7:0] ra, rm, y;
    logic [3:0] rf;
    logic sk, c;
    logic [8:0] sm;
    logic [4:0] lo;
    begin
      ra = a;
      rm = m;
      rf = f;
      sk = 1'b0;
      case (op)
        5'h00: begin rm = {m[6:0], f[0]}; rf[0] = m[7]; end
        5'h01: begin ra = {m[6:0], f[0]}; rf[0] = m[7]; end
        5'h02: rm = {m[0], m[7:1]};
        5'h03: ra = {m[0], m[7:1]};
        5'h04: begin rm = {f[0], m[7:1]}; rf[0] = m[0]; end
        5'h05: begin ra = {f[0], m[7:1]}; rf[0] = m[0]; end
        5'h08: begin rm = m - 8'h01; sk = (rm == 8'h00); end
        5'h09: begin ra = m - 8'h01; sk = (ra == 8'h00); end
        5'h0a: rm = 8'hff;
        5'h0b: rm[b] = 1'b1;
        5'h0c: begin rm = m + 8'h01; sk = (rm == 8'h00); end
        5'h0d: begin ra = m + 8'h01; sk = (ra == 8'h00); end
        5'h0e: sk = m[b];
        5'h12: rm = {m[3:0], m[7:4]};
        5'h13: ra = {m[3:0], m[7:4]};
        5'h06, 5'h07, 5'h0f, 5'h10, 5'h11: begin
          y = (op == 5'h11) ? i : m;
          c = (op == 5'h06 || op == 5'h07) ? f[0] : 1'b1;
          sm = {1'b0, a} + {1'b0, ~y} + {8'h00, c};
          lo = {1'b0, a[3:0]} + {1'b0, ~y[3:0]} + {4'h0, c};
          rf = {(a[7] == ~y[7]) && (sm[7] != a[7]), sm[7:0] == 8'h00, lo[4], sm[8]};
          if (op == 5'h07 || op == 5'h10) rm = sm[7:0];
          else ra = sm[7:0];
        end
        default: ;
      endcase
      model = {sk, rf, ra, rm};
    end
  endfunction
  initial forever #4 clk = ~clk;
  initial begin
    vec[0] = {8'h5a, 8'h81, 8'h33, 4'h1, 3'h7};
    vec[1] = {8'h80, 8'h01, 8'h01, 4'he, 3'h2};
    vec[2] = {8'h3c, 8'hff, 8'h3c, 4'h0, 3'h4};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 7; k++) rd_chk(k * 4, (k == 5) ? 32'h4 : 32'h0, 2'h0);
    rd_chk(8'h1c, 32'h0, 2'h2);
    wr(8'h1c, 32'h5, 4'hf, r);
    `CHK("bresp", 2'h2, r)
    skips = 0;
    runs = 0;
    for (s = 0; s < 3; s++) begin
      for (o = 0; o < 20; o++) begin
        {va, vm, vi, vf, vb} = vec[s];
        wr_ok(8'h04, {24'h0, va});
        wr_ok(8'h08, {24'h0, vm});
        wr_ok(8'h0c, {24'h0, vi});
        wr_ok(8'h10, {28'h0, vf});
        wr_ok(8'h00, {21'h0, vb, 3'h0, o[4:0]});
        e = model(o[4:0], va, vm, vi, vf, vb);
        for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clk);
        if (busy !== 1'b0) begin
          mismatches++;
          finish_test;
        end
        `CHK("acc", e[15:8], acc)
        `CHK("mem", e[7:0], mem)
        `CHK("flags", e[19:16], flags)
        `CHK("skip", e[20], skip)
        rd_chk(8'h14, {28'h0, e[20] ? 2'h2 : 2'h1, e[20], 1'b0}, 2'h0);
        skips += e[20];
        runs++;
      end
    end
    rd_chk(8'h18, {skips[15:0], runs[15:0]}, 2'h0);
    rd_chk(8'h04, {24'h0, e[15:8]}, 2'h0);
    wr(8'h04, 32'haa, 4'he, r);
    `CHK("bresp", 2'h0, r)
    `CHK("acc", e[15:8], acc)
    wr_ok(8'h00, 32'h1f);
    repeat (3) @(posedge clk);
    rd(8'h14, d, r);
    `CHK("bad_op", 1'b1, d[4])
    `CHK("acc", e[15:8], acc)
    finish_test;
  end
endmodule
`default_nettype wire
